// ### ebga_arbiter.sv
// External bus grant arbiter: hands the memory bus to an outside master
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Idle bus: float, grant, halt next cycle
// - Run-on-grant: halt only at external access
// - Busy bus: grant cycle after access completes
// - Grant allowed between two accesses
// - Request gone: ungrant, drive, resume
// - Arbitration works during boot and reset
// - Hung flag when external access blocked
// - Release clears grant, hung, then access
// - Emulator enable swaps pins, floats grant
module ebga_arbiter (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Normal pins, active low; grant drive enable active high
  input wire logic i_reset_n,
  input wire logic i_bus_request_in_n,
  output logic o_bus_grant_out_n,
  output logic o_bus_grant_out_oe,
  output logic o_grant_hung_out_n,
  // Emulator pins, active low; enable active high
  input wire logic i_emulator_enable,
  input wire logic i_emulator_reset_in_n,
  input wire logic i_emulator_bus_request_n,
  output logic o_emulator_bus_grant_n,
  // Core side
  input wire ebga_pkg::ebga_core_t i_core,
  output ebga_pkg::ebga_arb_t o_arb,
  output logic o_core_reset
);
  // Selected request, before synchronising
  wire raw_req = i_emulator_enable ? ~i_emulator_bus_request_n
                                   : ~i_bus_request_in_n;
  // Selected reset for the core
  wire raw_core_rst = i_emulator_enable ? ~i_emulator_reset_in_n
                                        : ~i_reset_n;
  // Synchronised request
  logic req_sync;
  // Request passes a synchroniser; the core reset does not gate it
  ebga_sync #(
    .STAGES(ebga_pkg::EBGA_SYNC_STAGES)
  ) u_req_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_level(raw_req),
    .o_level(req_sync)
  );

  // State register
  ebga_pkg::ebga_state_t state_reg;
  ebga_pkg::ebga_state_t state_next;
  // Output registers
  logic grant_reg;
  logic hung_reg;
  logic halt_reg;
  logic core_rst_reg;
  // Pin registers, so every pin comes straight from a flop
  logic oe_reg; // Normal grant pin drive enable
  logic gnt_pin_n_reg; // Normal grant pin level
  logic egnt_pin_n_reg; // Emulator grant pin level
  logic hung_pin_n_reg; // Hung-grant pin level

  // Decodes: a busy access defers grant; gaps between accesses allow it
  wire may_grant = req_sync & ~i_core.ext_busy;
  // Grant for the next cycle, before pin routing
  wire grant_next = (state_next == ebga_pkg::EBGA_GRANT);
  // Core stalls if it wants the bus while granted away
  wire blocked = i_core.ext_needed & grant_next;
  // Halt next: always in grant unless run-on-grant and not blocked
  wire halt_next = grant_next &
                   (~i_core.run_on_grant | i_core.ext_needed);
  // Grant goes out on exactly one of the two grant pins
  wire norm_gnt_next = grant_next & ~i_emulator_enable;
  wire emu_gnt_next = grant_next & i_emulator_enable;

  // Next-state logic; grant is never held by reset of the core
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ebga_pkg::EBGA_OWN: begin
        if (may_grant) begin
          state_next = ebga_pkg::EBGA_GRANT;
        end else if (req_sync) begin
          state_next = ebga_pkg::EBGA_WAIT;
        end
      end
      ebga_pkg::EBGA_WAIT: begin
        if (!req_sync) begin
          state_next = ebga_pkg::EBGA_OWN;
        end else if (may_grant) begin
          state_next = ebga_pkg::EBGA_GRANT;
        end
      end
      ebga_pkg::EBGA_GRANT: begin
        // Only a dropped request ends the grant
        if (!req_sync) begin
          state_next = ebga_pkg::EBGA_RESUME;
        end
      end
      ebga_pkg::EBGA_RESUME: begin
        // Drivers back for this cycle and one in OWN before a new grant
        state_next = ebga_pkg::EBGA_OWN;
      end
      default: begin
        state_next = ebga_pkg::EBGA_OWN;
      end
    endcase
  end

  // State and outputs; the device reset input does not stop this
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ebga_pkg::EBGA_OWN;
      grant_reg <= ebga_pkg::EBGA_GRANT_IDLE;
      hung_reg <= ebga_pkg::EBGA_GRANT_IDLE;
      halt_reg <= ebga_pkg::EBGA_GRANT_IDLE;
      core_rst_reg <= ebga_pkg::EBGA_GRANT_IDLE;
      // Pins released, normal grant pin driven
      oe_reg <= ebga_pkg::EBGA_OE_RESET;
      gnt_pin_n_reg <= ebga_pkg::EBGA_PIN_IDLE;
      egnt_pin_n_reg <= ebga_pkg::EBGA_PIN_IDLE;
      hung_pin_n_reg <= ebga_pkg::EBGA_PIN_IDLE;
    end else begin
      state_reg <= state_next;
      grant_reg <= grant_next;
      hung_reg <= blocked;
      halt_reg <= halt_next;
      core_rst_reg <= raw_core_rst;
      // Pin levels registered from the same decode as the flags
      oe_reg <= ~i_emulator_enable;
      gnt_pin_n_reg <= ~norm_gnt_next;
      egnt_pin_n_reg <= ~emu_gnt_next;
      hung_pin_n_reg <= ~blocked;
    end
  end

  // Pin drive: emulator mode routes grant to its pin, floats normal one
  assign o_bus_grant_out_n = gnt_pin_n_reg;
  assign o_bus_grant_out_oe = oe_reg;
  assign o_emulator_bus_grant_n = egnt_pin_n_reg;
  assign o_grant_hung_out_n = hung_pin_n_reg;
  // Core outputs
  assign o_arb.bus_grant_out = grant_reg;
  assign o_arb.grant_hung_out = hung_reg;
  assign o_arb.bus_float = grant_reg;
  assign o_arb.core_halt = halt_reg;
  assign o_core_reset = core_rst_reg;

  // Assertions
  sequence s_req_idle;
    req_sync && !i_core.ext_busy && state_reg == ebga_pkg::EBGA_OWN;
  endsequence
  property p_grant_next;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_req_idle |=> grant_reg && o_arb.bus_float;
  endproperty
  a_grant_next: assert property (p_grant_next)
    else $error("grant not given one cycle after idle request");
  property p_no_grant_busy;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!grant_reg && i_core.ext_busy) |=> !grant_reg;
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy)
    else $error("grant given during an external access");
  property p_release;
    @(posedge i_ref_clk) disable iff (i_rst)
      (grant_reg && !req_sync) |=> !grant_reg && !hung_reg;
  endproperty
  a_release: assert property (p_release)
    else $error("grant held after request dropped");
  property p_hung;
    @(posedge i_ref_clk) disable iff (i_rst)
      hung_reg |-> grant_reg && o_arb.core_halt;
  endproperty
  a_hung: assert property (p_hung)
    else $error("hung flag without grant and halt");
  property p_run_on;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_core.run_on_grant && !i_core.ext_needed) |=> !halt_reg;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("halted in run-on-grant without need");
  property p_emu_float;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_emulator_enable |=> !o_bus_grant_out_oe && o_bus_grant_out_n;
  endproperty
  a_emu_float: assert property (p_emu_float)
    else $error("normal grant driven in emulator mode");
  property p_emu_route;
    @(posedge i_ref_clk) disable iff (i_rst)
      (grant_reg && !o_bus_grant_out_oe) |-> !o_emulator_bus_grant_n;
  endproperty
  a_emu_route: assert property (p_emu_route)
    else $error("emulator grant pin idle while granted");
  property p_oe_back;
    @(posedge i_ref_clk) disable iff (i_rst)
      !i_emulator_enable |=> o_bus_grant_out_oe && o_emulator_bus_grant_n;
  endproperty
  a_oe_back: assert property (p_oe_back)
    else $error("normal grant pin not back in normal mode");
  property p_release_run;
    @(posedge i_ref_clk) disable iff (i_rst)
      (grant_reg && !req_sync) |=> !o_arb.core_halt && o_bus_grant_out_n;
  endproperty
  a_release_run: assert property (p_release_run)
    else $error("core still halted after request dropped");
  // A new grant needs two cycles with the drivers back on
  property p_resume_gap;
    @(posedge i_ref_clk) disable iff (i_rst)
      $fell(grant_reg) |=> !grant_reg;
  endproperty
  a_resume_gap: assert property (p_resume_gap)
    else $error("grant regained without resume cycle");
  property p_reset_ok;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_core_reset ##0 s_req_idle) |=> grant_reg;
  endproperty
  a_reset_ok: assert property (p_reset_ok)
    else $error("arbitration stopped under core reset");
  property p_sync;
    @(posedge i_ref_clk) disable iff (i_rst)
      (raw_req [*3]) |-> req_sync;
  endproperty
  a_sync: assert property (p_sync)
    else $error("request not through synchroniser");
endmodule
`default_nettype wire

// ### ebga_arbiter_tb.sv
// Self-checking bench for the external bus grant arbiter
`timescale 1ns/1ns
`default_nettype none
module ebga_arbiter_tb;
  logic i_ref_clk = 1'h0; // Bench clock
  logic i_rst = 1'h1; // Design reset
  logic i_reset_n = 1'h1; // Device reset pin
  logic want = 1'h0; // Master needs the bus
  logic emu = 1'h0; // Emulator select
  logic emu_rst_n = 1'h1; // Emulator reset pin
  logic emu_req_n = 1'h1; // Emulator request pin
  ebga_pkg::ebga_core_t core = '0; // Core handshake
  ebga_pkg::ebga_arb_t arb; // Arbiter outputs
  logic req_n, gnt_n, oe, hung_n, egnt_n, core_rst, drive;
  // Grant line as the master sees it: the emulator drives it from its
  // own grant while the normal pin floats
  wire model_gnt_n = oe ? gnt_n : egnt_n;
  int n_errors = 0;
  int checked = 0;
  // 100 MHz clock
  initial forever #5 i_ref_clk = !i_ref_clk;
  ebga_master_model i_master (.i_ref_clk(i_ref_clk), .i_want(want),
    .i_grant_n(model_gnt_n), .o_request_n(req_n), .o_drive(drive));
  ebga_arbiter i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_reset_n(i_reset_n), .i_bus_request_in_n(req_n),
    .o_bus_grant_out_n(gnt_n), .o_bus_grant_out_oe(oe),
    .o_grant_hung_out_n(hung_n), .i_emulator_enable(emu),
    .i_emulator_reset_in_n(emu_rst_n),
    .i_emulator_bus_request_n(emu_req_n),
    .o_emulator_bus_grant_n(egnt_n), .i_core(core), .o_arb(arb),
    .o_core_reset(core_rst));
  // One comparison
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Just past the edge, so inputs and samples share one offset
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Edges until the chosen grant pin reaches a level, bounded
  task automatic wgrant(input string what, input logic sel_emu,
      input logic lvl, input int exp);
    int n;
    n = 0;
    do begin
      step(1);
      n++;
    end while ((sel_emu ? egnt_n : gnt_n) !== lvl && n < 12);
    chk(what, exp[7:0], n[7:0]);
    if (n >= 12) give_verdict();
  endtask
  // Idle bus, model adds one edge before its pin moves
  task automatic sc_idle;
    want = 1'h1;
    wgrant("grant idle", 1'h0, 1'h0, 4);
    chk("float", 1'h1, arb.bus_float);
    chk("grant field", 1'h1, arb.bus_grant_out);
    chk("master drive", 1'h1, drive);
    chk("halt", 1'h1, arb.core_halt);
    chk("grant oe", 1'h1, oe);
    want = 1'h0;
    wgrant("ungrant", 1'h0, 1'h1, 4);
    chk("drive again", 1'h0, arb.bus_float);
    chk("resume", 1'h0, arb.core_halt);
    step(2);
  endtask
  // Request during an access, second access pending
  task automatic sc_busy;
    core.ext_busy = 1'h1;
    core.ext_needed = 1'h1;
    want = 1'h1;
    step(8);
    chk("deferred grant", 1'h1, gnt_n);
    chk("still driving", 1'h0, arb.bus_float);
    core.ext_busy = 1'h0;
    wgrant("grant between", 1'h0, 1'h0, 1);
    chk("hung", 1'h0, hung_n);
    chk("hung field", 1'h1, arb.grant_hung_out);
    want = 1'h0;
    wgrant("ungrant hung", 1'h0, 1'h1, 4);
    chk("hung off", 1'h1, hung_n);
    core = '0;
    step(2);
  endtask
  // Run-on-grant stalls only at an external access
  task automatic sc_run;
    core.run_on_grant = 1'h1;
    want = 1'h1;
    wgrant("grant run", 1'h0, 1'h0, 4);
    chk("no halt", 1'h0, arb.core_halt);
    chk("no hung", 1'h1, hung_n);
    core.ext_needed = 1'h1;
    step(1);
    chk("halt at access", 1'h1, arb.core_halt);
    chk("hung at access", 1'h0, hung_n);
    want = 1'h0;
    wgrant("ungrant run", 1'h0, 1'h1, 4);
    core = '0;
    step(2);
  endtask
  // Arbitration with the device reset pin held
  task automatic sc_reset;
    i_reset_n = 1'h0;
    step(2);
    chk("core reset", 1'h1, core_rst);
    sc_idle();
    i_reset_n = 1'h1;
    step(2);
    chk("core run", 1'h0, core_rst);
  endtask
  // Emulator pins take over, normal grant floats
  task automatic sc_emu;
    emu = 1'h1;
    emu_rst_n = 1'h0;
    want = 1'h1;
    step(6);
    chk("grant float", 1'h0, oe);
    chk("emu reset", 1'h1, core_rst);
    chk("normal ignored", 1'h1, egnt_n);
    chk("no drive", 1'h0, drive);
    emu_rst_n = 1'h1;
    emu_req_n = 1'h0;
    wgrant("emu grant", 1'h1, 1'h0, 3);
    chk("pin idle", 1'h1, gnt_n);
    chk("emu drive", 1'h1, drive);
    emu_req_n = 1'h1;
    want = 1'h0;
    wgrant("emu ungrant", 1'h1, 1'h1, 3);
    emu = 1'h0;
    step(2);
  endtask
  // Main sequence
  initial begin
    step(16);
    i_rst = 1'h0;
    step(2);
    sc_idle();
    sc_busy();
    sc_run();
    sc_reset();
    sc_emu();
    sc_idle();
    give_verdict();
  end
endmodule
`default_nettype wire

// ### ebga_master_model.sv
// Model of the outside bus master sharing the memory bus
`timescale 1ns/1ns
`default_nettype none
module ebga_master_model (
  // Clock
  input wire logic i_ref_clk,
  // Need from the bench, grant from the device
  input wire logic i_want,
  input wire logic i_grant_n,
  // Request pin and own bus drive
  output logic o_request_n,
  output logic o_drive
);
  // Idle master holds its request off, then follows need one edge late
  initial begin
    o_request_n = 1'h1;
    forever begin
      @(posedge i_ref_clk);
      o_request_n <= #1 !i_want;
    end
  end
  // Drives the bus only while grant is asserted
  assign o_drive = i_want && !i_grant_n;
endmodule
`default_nettype wire

// ### ebga_pkg.sv
// Package for the external bus grant arbiter: states and carrier structs
package ebga_pkg;
  // Arbiter states, one-hot
  typedef enum logic [3:0] {
    EBGA_OWN = 4'h1, // Device owns the bus
    EBGA_WAIT = 4'h2, // Request seen, access still finishing
    EBGA_GRANT = 4'h4, // Bus granted away
    EBGA_RESUME = 4'h8 // Request dropped, drivers back on
  } ebga_state_t;
  // Synchroniser depth
  localparam int EBGA_SYNC_STAGES = 2;
  // Reset level of the active-high flags inside the block
  localparam logic EBGA_GRANT_IDLE = 1'h0;
  // Reset level of the active-low pins: released
  localparam logic EBGA_PIN_IDLE = 1'h1;
  // Normal grant pin is driven out of reset
  localparam logic EBGA_OE_RESET = 1'h1;
  // Core-side handshake from the sequencer
  typedef struct packed {
    logic ext_busy; // External access in progress this cycle
    logic ext_needed; // Next instruction needs the external bus
    logic run_on_grant; // Keep running after grant
  } ebga_core_t;
  // Core-side arbitration outputs
  typedef struct packed {
    logic bus_grant_out; // Grant, active high inside
    logic grant_hung_out; // Core stalled on granted bus
    logic bus_float; // Float data, address and strobes
    logic core_halt; // Stop the sequencer
  } ebga_arb_t;
endpackage

// ### ebga_sync.sv
// Two-flop level synchroniser for the bus request
`timescale 1ns/1ns
`default_nettype none
module ebga_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Level in and out
  input wire logic i_level,
  output logic o_level
);
  // Shift chain; only the last stage is read
  logic [STAGES-1:0] chain_reg;
  // One stage alone would pass a metastable level straight on
  if (STAGES < 2) begin : g_stages_bad
    $error("ebga_sync needs at least two stages");
  end
  // Chain advances every edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], i_level};
    end
  end
  assign o_level = chain_reg[STAGES-1];
endmodule
`default_nettype wire
